// [logic/out_logic_pkg.sv]
// constants for the output logic and delay unit: register map, fields, reset values, timing.
// assumes a 25 MHz control clock and a word-aligned register port.
package out_logic_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_PERIOD_MS = 100; // 0.1 s delay step
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned RST_HOLD_MS = 1000; // extra on-time after reset input
  localparam int unsigned RST_HOLD_TICKS = RST_HOLD_MS / TICK_PERIOD_MS;
  localparam int unsigned DELAY_MAX_TENTHS = 1000; // 100.0 s

  // widths
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DLY_W = 10;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned NUM_STATUS = 9;
  localparam int unsigned NUM_OUT = 3;

  // register byte offsets
  localparam logic [5:0] LOGIC_CFG_OFS = 6'h00;
  localparam logic [5:0] FUNC_SEL_OFS = 6'h04;
  localparam logic [5:0] DELAY_BASE_OFS = 6'h08; // six words: 11 on/off, 12 on/off, relay on/off
  localparam logic [5:0] STATUS_OFS = 6'h20;
  localparam logic [5:0] CONTROL_OFS = 6'h24;
  localparam int unsigned NUM_DELAY_REGS = 6;

  // logic config fields
  localparam int unsigned OPA_LSB = 0;
  localparam int unsigned OPB_LSB = 4;
  localparam int unsigned COMB_LSB = 8;
  // function select fields
  localparam int unsigned T11_FN_LSB = 0;
  localparam int unsigned T12_FN_LSB = 4;
  localparam int unsigned RLY_FN_LSB = 8;
  localparam int unsigned RSTRESP_LSB = 12;
  // control fields
  localparam int unsigned CTRL_RESTORE_BIT = 0;

  // codes
  localparam logic [1:0] COMB_AND = 2'h0;
  localparam logic [1:0] COMB_OR = 2'h1;
  localparam logic [1:0] COMB_XOR = 2'h2;
  localparam logic [1:0] RESP_RISE_STOP = 2'h0;
  localparam logic [1:0] RESP_FALL_STOP = 2'h1;
  localparam logic [1:0] RESP_RISE_RUN = 2'h2;
  localparam logic [3:0] FN_COMBINED = 4'h9; // codes 0..8 pick a status input

  // factory defaults
  localparam logic [3:0] OPA_RESET = 4'h0;
  localparam logic [3:0] OPB_RESET = 4'h1;
  localparam logic [1:0] COMB_RESET = 2'h0;
  localparam logic [1:0] RESP_RESET = 2'h0;
  localparam logic [3:0] FN_RESET = 4'h0;
  localparam logic [9:0] DELAY_RESET = 10'h000;
endpackage

// [logic/out_logic_unit.sv]
// output logic combiner, per-output on/off delay and reset-input handling for a drive's discrete outputs.
// assumes all inputs synchronous to mclk and a register master that never needs a wait state.
`timescale 1ns/10ps

// How it works
// - operands A and B each pick one of nine status inputs independently
// - combine code 0 gives AND, 1 gives OR, 2 gives XOR
// - defaults: operand A selects code 0, combine operation is AND
// - default: operand B selects code 1
// - combined result is selectable by each of terminal 11, 12 and relay
// - each of the three outputs has separate on and off delays
// - delays count in 0.1 s steps, at most 100.0 s, before the change
// - six delays range 0.0 to 100.0 s, default 0.0 meaning no delay
// - without off delay, reset input drops outputs at once, and motor run too in reset responses 0 and 1
// - with off delay above zero, output holds one extra second after reset input
// - reset response: 0 rise clears and stops, 1 fall clears and stops, 2 rise only
module out_logic_unit
  import out_logic_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_STATUS-1:0] status_in,
  input wire logic trip_clear_terminal,
  input wire logic trip_event,
  input wire logic run_cmd,
  output logic motor_run,
  output logic trip_active,
  output logic term11_out,
  output logic term12_out,
  output logic relay_out
);

  if (TICK_LEN < 2) begin : g_bad_tick
    $error("TICK_LEN must be at least 2");
  end

  // reset release through two flops
  logic rst_meta_q, rst_sync_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_q;

  // configuration registers
  logic [3:0] opa_q, opa_d, opb_q, opb_d;
  logic [1:0] comb_q, comb_d, resp_q, resp_d;
  logic [3:0] fn_q [NUM_OUT];
  logic [3:0] fn_d [NUM_OUT];
  logic [DLY_W-1:0] dly_q [NUM_DELAY_REGS];
  logic [DLY_W-1:0] dly_d [NUM_DELAY_REGS];
  logic [31:0] rdata_d;
  logic [NUM_OUT-1:0] out_q;

  // clamp a written delay to the 100.0 s ceiling
  function automatic logic [DLY_W-1:0] clamp_delay(input logic [31:0] v);
    if (v > 32'(DELAY_MAX_TENTHS))
      return DLY_W'(DELAY_MAX_TENTHS);
    return v[DLY_W-1:0];
  endfunction

  // register writes; restore command reloads every factory default
  always_comb begin
    opa_d = opa_q;
    opb_d = opb_q;
    comb_d = comb_q;
    resp_d = resp_q;
    fn_d = fn_q;
    dly_d = dly_q;
    if (reg_wr) begin
      if (reg_addr == LOGIC_CFG_OFS) begin
        opa_d = reg_wdata[OPA_LSB +: SEL_W];
        opb_d = reg_wdata[OPB_LSB +: SEL_W];
        comb_d = reg_wdata[COMB_LSB +: 2];
      end
      if (reg_addr == FUNC_SEL_OFS) begin
        fn_d[0] = reg_wdata[T11_FN_LSB +: SEL_W];
        fn_d[1] = reg_wdata[T12_FN_LSB +: SEL_W];
        fn_d[2] = reg_wdata[RLY_FN_LSB +: SEL_W];
        resp_d = reg_wdata[RSTRESP_LSB +: 2];
      end
      for (int i = 0; i < NUM_DELAY_REGS; i++) begin
        if (reg_addr == DELAY_BASE_OFS + 6'(4 * i))
          dly_d[i] = clamp_delay(reg_wdata);
      end
      if (reg_addr == CONTROL_OFS && reg_wdata[CTRL_RESTORE_BIT]) begin
        opa_d = OPA_RESET;
        opb_d = OPB_RESET;
        comb_d = COMB_RESET;
        resp_d = RESP_RESET;
        for (int i = 0; i < NUM_OUT; i++)
          fn_d[i] = FN_RESET;
        for (int i = 0; i < NUM_DELAY_REGS; i++)
          dly_d[i] = DELAY_RESET;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opa_q <= OPA_RESET;
      opb_q <= OPB_RESET;
      comb_q <= COMB_RESET;
      resp_q <= RESP_RESET;
      for (int i = 0; i < NUM_OUT; i++)
        fn_q[i] <= FN_RESET;
      for (int i = 0; i < NUM_DELAY_REGS; i++)
        dly_q[i] <= DELAY_RESET;
    end else begin
      opa_q <= opa_d;
      opb_q <= opb_d;
      comb_q <= comb_d;
      resp_q <= resp_d;
      fn_q <= fn_d;
      dly_q <= dly_d;
    end
  end

  // 0.1 s tick divider
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    if (tick_cnt_q == 32'(TICK_LEN - 1)) begin
      tick_cnt_d = 32'h0000_0000;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // two-operand combiner
  // selector codes above 8 read as zero rather than wrapping
  function automatic logic pick_status(input logic [3:0] sel, input logic [NUM_STATUS-1:0] s);
    if (sel < 4'(NUM_STATUS))
      return s[sel];
    return 1'b0;
  endfunction

  logic op_a, op_b, comb_out;
  always_comb begin
    op_a = pick_status(opa_q, status_in);
    op_b = pick_status(opb_q, status_in);
    case (comb_q)
      COMB_AND: comb_out = op_a & op_b;
      COMB_OR: comb_out = op_a | op_b;
      COMB_XOR: comb_out = op_a ^ op_b;
      default: comb_out = 1'b0;
    endcase
  end

  // trip clear input and trip flag
  logic rsin_prev_q, trip_q, trip_d, run_q, run_d;
  logic clr_rise, clr_fall, clr_edge, clr_stop;
  always_comb begin
    clr_rise = trip_clear_terminal & ~rsin_prev_q;
    clr_fall = ~trip_clear_terminal & rsin_prev_q;
    case (resp_q)
      RESP_RISE_STOP: begin
        clr_edge = clr_rise;
        clr_stop = trip_clear_terminal;
      end
      RESP_FALL_STOP: begin
        clr_edge = clr_fall;
        clr_stop = trip_clear_terminal;
      end
      RESP_RISE_RUN: begin
        clr_edge = clr_rise;
        clr_stop = 1'b0;
      end
      default: begin
        clr_edge = clr_rise;
        clr_stop = trip_clear_terminal;
      end
    endcase
    // a trip arriving with the clear edge wins
    trip_d = trip_event | (trip_q & ~clr_edge);
    run_d = run_cmd & ~trip_d & ~clr_stop;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsin_prev_q <= 1'b0;
      trip_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      rsin_prev_q <= trip_clear_terminal;
      trip_q <= trip_d;
      run_q <= run_d;
    end
  end

  // per-output delay channels
  // tick phase is free-running, so a delay of n steps lasts between n-1 and n steps
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_chan
    logic src, want_on;
    logic [DLY_W-1:0] on_dly, off_dly, use_dly;
    logic [DLY_W-1:0] cnt_q, cnt_d;
    logic out_d;
    always_comb begin
      on_dly = dly_q[2 * g];
      off_dly = dly_q[2 * g + 1];
      if (fn_q[g] == FN_COMBINED)
        src = comb_out;
      else
        src = pick_status(fn_q[g], status_in);
      want_on = src & ~trip_clear_terminal;
      use_dly = want_on ? on_dly : off_dly;
      // reset input turns any non-zero off delay into the fixed one-second hold
      if (!want_on && trip_clear_terminal && off_dly != DELAY_RESET)
        use_dly = DLY_W'(RST_HOLD_TICKS);
      out_d = out_q[g];
      cnt_d = cnt_q;
      if (want_on == out_q[g]) begin
        cnt_d = '0;
      end else if (use_dly == DELAY_RESET) begin
        out_d = want_on;
        cnt_d = '0;
      end else if (tick_q) begin
        if (cnt_q + 10'h001 >= use_dly) begin
          out_d = want_on;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 10'h001;
        end
      end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= '0;
        out_q[g] <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        out_q[g] <= out_d;
      end
    end
  end

  // read port, data registered one cycle after the strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == LOGIC_CFG_OFS) begin
        rdata_d[OPA_LSB +: SEL_W] = opa_q;
        rdata_d[OPB_LSB +: SEL_W] = opb_q;
        rdata_d[COMB_LSB +: 2] = comb_q;
      end
      if (reg_addr == FUNC_SEL_OFS) begin
        rdata_d[T11_FN_LSB +: SEL_W] = fn_q[0];
        rdata_d[T12_FN_LSB +: SEL_W] = fn_q[1];
        rdata_d[RLY_FN_LSB +: SEL_W] = fn_q[2];
        rdata_d[RSTRESP_LSB +: 2] = resp_q;
      end
      for (int i = 0; i < NUM_DELAY_REGS; i++) begin
        if (reg_addr == DELAY_BASE_OFS + 6'(4 * i))
          rdata_d[DLY_W-1:0] = dly_q[i];
      end
      if (reg_addr == STATUS_OFS) begin
        rdata_d[2:0] = out_q;
        rdata_d[3] = comb_out;
        rdata_d[4] = trip_q;
        rdata_d[5] = run_q;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= rdata_d;
  end

  // outputs are flops already
  assign term11_out = out_q[0];
  assign term12_out = out_q[1];
  assign relay_out = out_q[2];
  assign motor_run = run_q;
  assign trip_active = trip_q;

endmodule

// [verif/out_logic_watcher.sv]
// far-side model: equipment watching the three discrete outputs
// assumes the outputs are plain levels sampled on mclk
`timescale 1ns/10ps
module out_watcher (
  input wire logic mclk,
  input wire logic [2:0] outs,
  output int unsigned changes
);
  logic [2:0] last_q;
  initial changes = 0;
  // count every level change; a relay coil sees glitches too
  always @(posedge mclk) begin
    if (outs !== last_q) begin
      changes <= changes + 1;
    end
    last_q <= outs;
  end
endmodule

// [verif/out_logic_unit_assertions.sv]
// port checker for the output logic unit
// assumes the package register map; bound at the foot
`timescale 1ns/10ps
module out_logic_chk
  import out_logic_pkg::*;
#(
  parameter int unsigned TICK_LEN = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUM_STATUS-1:0] status_in,
  input wire logic trip_clear_terminal,
  input wire logic trip_event,
  input wire logic run_cmd,
  input wire logic motor_run,
  input wire logic trip_active,
  input wire logic term11_out,
  input wire logic term12_out,
  input wire logic relay_out
);
  localparam int HOLD_CYC = 12 * TICK_LEN + 4;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // cycles the reset input stayed high, saturating
  always_comb begin
    hi_d = trip_clear_terminal ? hi_q + {7'h00, hi_q != 8'hff} : 8'h00;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= hi_d;
    end
  end
  sequence s_restore;
    reg_wr && reg_addr == CONTROL_OFS && reg_wdata[0];
  endsequence
  sequence s_rd_cfg;
    reg_rd && reg_addr == LOGIC_CFG_OFS;
  endsequence
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_unmapped;
    reg_rd && reg_addr == 6'h3c |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_status;
    reg_rd && reg_addr == STATUS_OFS |=> reg_rdata == {26'h000_0000, $past(motor_run), $past(trip_active),
      reg_rdata[3], $past(relay_out), $past(term12_out), $past(term11_out)};
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");
  property p_restore;
    s_restore ##1 !reg_wr ##1 s_rd_cfg |=> reg_rdata[9:0] == {COMB_RESET, OPB_RESET, OPA_RESET};
  endproperty
  a_restore: assert property (p_restore) else $error("restore values wrong");
  property p_trip_set;
    trip_event |=> trip_active;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip not set");
  property p_trip_hold;
    trip_active && !trip_clear_terminal && !$past(trip_clear_terminal) && !$past(trip_clear_terminal, 2)
      |=> trip_active;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip lost");
  property p_run_trip;
    (trip_active |-> !motor_run) and (!run_cmd |=> !motor_run);
  endproperty
  a_run_trip: assert property (p_run_trip) else $error("run while tripped");
  property p_run_ok;
    run_cmd && !trip_active && !trip_clear_terminal |=> motor_run == !$past(trip_event);
  endproperty
  a_run_ok: assert property (p_run_ok) else $error("run missing");
  property p_hold_off;
    int'(hi_q) > HOLD_CYC |-> !term11_out && !term12_out && !relay_out;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("output on after hold");
  property p_rst_out;
    disable iff (1'h0) !resetn |-> !term11_out && !term12_out && !relay_out && !motor_run;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("output on in reset");
endmodule

bind out_logic_unit out_logic_chk #(.TICK_LEN(TICK_LEN)) chk (.*);

// [verif/output_logic_and_delay_unit_bench.sv]
// self-checking bench for the output logic unit
// assumes a short tick of 4 cycles
`timescale 1ns/10ps
module output_logic_and_delay_unit_bench;
  import out_logic_pkg::*;
  localparam int unsigned T = 4;
  logic mclk = 1'h0;
  logic resetn = 1'h1;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic [8:0] status_in = 9'h000;
  logic trip_clear_terminal = 1'h0;
  logic trip_event = 1'h0;
  logic run_cmd = 1'h0;
  logic motor_run, trip_active, term11_out, term12_out, relay_out;
  int unsigned changes, mismatches = 0, total_checks = 0, cycles = 0;
  always #20 mclk = ~mclk;
  out_logic_unit #(.TICK_LEN(T)) dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .status_in(status_in), .trip_clear_terminal(trip_clear_terminal), .trip_event(trip_event),
    .run_cmd(run_cmd), .motor_run(motor_run), .trip_active(trip_active), .term11_out(term11_out),
    .term12_out(term12_out), .relay_out(relay_out));
  out_watcher mon (.mclk(mclk), .outs({relay_out, term12_out, term11_out}), .changes(changes));
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // settle past the edge so no update races the look
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic t_defaults;
    rdc(LOGIC_CFG_OFS, 32'h0000_0010);
    rdc(FUNC_SEL_OFS, 32'h0000_0000);
    for (int i = 0; i < 6; i++) rdc(DELAY_BASE_OFS + 6'(4 * i), 32'h0000_0000);
    rdc(6'h3c, 32'h0000_0000);
    $display("test defaults done");
  endtask
  // every operator over every operand pair, then a restore
  task automatic t_combine;
    logic a, b, e;
    wr(FUNC_SEL_OFS, 32'h0000_0929);
    for (int op = 0; op < 3; op++) for (int v = 0; v < 4; v++) begin
      a = v[0];
      b = v[1];
      e = (op == 0) ? (a & b) : (op == 1) ? (a | b) : (a ^ b);
      wr(LOGIC_CFG_OFS, {22'h00_0000, 2'(op), 8'h53}); // operand b bit 5, a bit 3
      @(posedge mclk);
      status_in <= {3'h0, b, 1'h0, a, b, 2'h0};
      cyc(3);
      chk(term11_out, e);
      chk(relay_out, e);
      chk(term12_out, b);
      rdc(STATUS_OFS, {28'h000_0000, e, e, b, e});
    end
    wr(CONTROL_OFS, 32'h0000_0001);
    rdc(LOGIC_CFG_OFS, 32'h0000_0010);
    $display("test combine done");
  endtask
  task automatic t_delay;
    int unsigned c0;
    wr(FUNC_SEL_OFS, 32'h0000_0ff0);
    wr(DELAY_BASE_OFS, 32'h0000_07d0);
    rdc(DELAY_BASE_OFS, 32'h0000_03e8);
    wr(DELAY_BASE_OFS, 32'h0000_0003);
    @(posedge mclk);
    status_in <= 9'h000;
    cyc(3);
    c0 = changes;
    // a pulse one cycle short of two ticks must vanish
    @(posedge mclk);
    status_in <= 9'h001;
    cyc(2 * T - 2);
    @(posedge mclk);
    status_in <= 9'h000;
    cyc(5 * T);
    chk(changes, c0);
    @(posedge mclk);
    status_in <= 9'h001;
    cyc(2 * T - 2);
    chk(term11_out, 1'h0);
    cyc(T + 4);
    chk(term11_out, 1'h1);
    @(posedge mclk);
    status_in <= 9'h000;
    cyc(2);
    chk(term11_out, 1'h0);
    wr(DELAY_BASE_OFS, 32'h0000_0000);
    $display("test delay done");
  endtask
  task automatic t_rstin;
    wr(FUNC_SEL_OFS, 32'h0000_0f00);
    wr(6'h14, 32'h0000_0005);
    @(posedge mclk);
    status_in <= 9'h001;
    run_cmd <= 1'h1;
    cyc(4);
    chk(motor_run, 1'h1);
    chk(term12_out, 1'h1);
    @(posedge mclk);
    trip_clear_terminal <= 1'h1;
    cyc(2);
    chk(term11_out, 1'h0);
    chk(motor_run, 1'h0);
    cyc(8 * T);
    chk(term12_out, 1'h1);
    cyc(5 * T);
    chk(term12_out, 1'h0);
    @(posedge mclk);
    trip_clear_terminal <= 1'h0;
    status_in <= 9'h000;
    wr(6'h14, 32'h0000_0000);
    $display("test reset input done");
  endtask
  task automatic t_trip;
    for (int r = 0; r < 3; r++) begin
      wr(FUNC_SEL_OFS, {18'h0_0000, 2'(r), 12'h000});
      @(posedge mclk);
      trip_event <= 1'h1;
      run_cmd <= 1'h1;
      @(posedge mclk);
      trip_event <= 1'h0;
      cyc(2);
      chk(trip_active, 1'h1);
      @(posedge mclk);
      trip_clear_terminal <= 1'h1;
      cyc(3);
      chk(trip_active, r == 1);
      chk(motor_run, r == 2);
      @(posedge mclk);
      trip_clear_terminal <= 1'h0;
      cyc(3);
      chk(trip_active, 1'h0);
    end
    $display("test trip done");
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    // a real falling edge at time zero so every flop with a reset is cleared before the first clock
    resetn <= 1'h0;
    repeat (12) @(posedge mclk);
    resetn <= 1'h1;
    cyc(4);
    t_defaults();
    t_combine();
    t_delay();
    t_rstin();
    t_trip();
    test_done();
  end
endmodule
